// ==== verilog/cst_sequencer.v ====
// self-test sequencer with entropy health monitoring
// Summary of operation
// - any failed test enters error, requests module reset, then reruns power-up tests
// - in error state all data output and crypto starts are blocked
// - with a pass record set, skip firmware tests; run integrity and hardware tests
// - fetch the persisted pass record before choosing which tests to run
// - power-up tests start automatically; services and I/O held off meanwhile
// - caller completion withheld until tests finish; operational only after all pass
// - integrity digest computed at run time compared to stored digest; mismatch fails
// - hardware checks: block cipher encrypt/decrypt, two keyed-hash variants
// - firmware checks: mac, signature, oaep, drbg, kdf, ecdh, one-step kdf
// - each known-answer result compared to expected; any difference fails
// - curve signature pairwise check: sign or verify failure enters error
// - every curve or rsa key generation triggers a sign-and-verify pairwise check
// - each entropy block equal to its predecessor flags a failure
// - a value repeated consecutively beyond the cutoff flags a failure
// - a value far too common inside a window flags a failure
// - entropy monitor starts after every reset and runs continuously
// - entropy samples arrive as a continuous 256-bit stream
// - short pattern counts checked against expected binomial bounds
// - conditioned entropy output delivers 256 bits per word
`timescale 1ns/1ps
`include "cst_regs.vh"
module cst_sequencer #(
  parameter SW = `CST_SAMPLE_W,
  parameter N_HW = 4,
  parameter N_FW = 9,
  parameter FIFO_DEPTH = 8,
  parameter FIFO_AW = 3
) (
  // clock and reset
  input wire clk,
  input wire reset_n,
  // persisted pass record in battery-backed storage
  output reg rec_rd_q,
  input wire rec_valid,
  input wire rec_passed,
  output reg rec_wr_q,
  // integrity check engine
  output reg integ_start_q,
  input wire integ_done,
  input wire [255:0] integ_digest,
  input wire [255:0] integ_stored,
  // known-answer checks: one start per test, result and expected
  output reg kat_start_q,
  output reg [3:0] kat_sel_q,
  input wire kat_done,
  input wire [511:0] kat_result,
  input wire [511:0] kat_expected,
  // key generation and pairwise check
  input wire keygen_done,
  output reg pct_start_q,
  input wire pct_done,
  input wire pct_sign_ok,
  input wire pct_verify_ok,
  // entropy source stream
  input wire ent_valid,
  output wire ent_ready,
  input wire [SW-1:0] ent_data,
  // entropy output to consumers
  output reg ent_out_valid_q,
  output reg [SW-1:0] ent_out_data_q,
  input wire ent_out_ready,
  // caller and services
  input wire svc_req,
  output reg svc_done_q,
  output reg operational_q,
  output reg out_enable_q,
  output reg crypto_allow_q,
  output reg fail_q,
  output reg module_reset_q
);
  localparam S_FETCH = 3'h0;
  localparam S_INTEG = 3'h1;
  localparam S_HW = 3'h2;
  localparam S_FW = 3'h3;
  localparam S_OPER = 3'h4;
  localparam S_PCT = 3'h5;
  localparam S_ERR = 3'h6;
  localparam S_WAIT = 3'h7;

  reg [2:0] st_q;
  reg skip_fw_q;
  reg [3:0] idx_q;
  reg issued_q;
  reg [7:0] hold_q;
  reg pend_q;
  reg ent_ok_q;
  reg [7:0] warm_q;

  // entropy samples are buffered; sampling regions are the fifo output
  wire s_valid;
  wire [SW-1:0] s_data;
  wire s_ready = !ent_out_valid_q || ent_out_ready;
  wire s_take = s_valid && s_ready;

  // eight words ride out short consumer stalls; a full buffer back-pressures the source
  cst_fifo #(.WIDTH(SW), .DEPTH(FIFO_DEPTH), .AW(FIFO_AW)) u_fifo (
    .clk(clk),
    .reset_n(reset_n),
    .in_valid(ent_valid),
    .in_ready(ent_ready),
    .in_data(ent_data),
    .out_valid(s_valid),
    .out_ready(s_ready),
    .out_data(s_data)
  );

  // repeated-block check
  reg [SW-1:0] prev_q;
  reg have_prev_q;
  wire rbc_fail = s_take && have_prev_q && (s_data == prev_q);

  // repetition and proportion on the low pattern of each sample
  wire [`CST_PAT_W-1:0] pat = s_data[`CST_PAT_W-1:0];
  reg [`CST_PAT_W-1:0] last_pat_q;
  reg [7:0] run_q;
  reg [`CST_PAT_W-1:0] ref_pat_q;
  reg [15:0] win_q;
  reg [15:0] hit_q;
  wire rct_fail = s_take && have_prev_q && (pat == last_pat_q)
      && (run_q >= `CST_RCT_CUTOFF);
  wire win_end = s_take && (win_q == `CST_APT_WINDOW - 16'h0001);
  wire [15:0] hit_n = hit_q + {15'h0000, (pat == ref_pat_q)};
  wire apt_fail = s_take && (hit_n > `CST_APT_CUTOFF);
  wire bin_fail = win_end && (hit_n < `CST_APT_LOW);
  // any one of the four monitor checks stops the block
  wire ent_fail = rbc_fail || rct_fail || apt_fail || bin_fail;

  // monitor runs unconditionally from reset onward
  always @(posedge clk) begin
    if (!reset_n) begin
      prev_q <= {SW{1'b0}};
      have_prev_q <= 1'b0;
      last_pat_q <= {`CST_PAT_W{1'b0}};
      run_q <= 8'h00;
      ref_pat_q <= {`CST_PAT_W{1'b0}};
      win_q <= 16'h0000;
      hit_q <= 16'h0000;
      warm_q <= 8'h00;
      ent_ok_q <= 1'b0;
    end else if (s_take) begin
      prev_q <= s_data;
      have_prev_q <= 1'b1;
      last_pat_q <= pat;
      // run count restarts on any change of pattern; cutoff counts extra repeats
      run_q <= (have_prev_q && pat == last_pat_q) ? run_q + 8'h01 : 8'h00;
      if (win_q == 16'h0000) begin
        ref_pat_q <= pat;
        hit_q <= 16'h0001;
      end else begin
        hit_q <= hit_n;
      end
      win_q <= win_end ? 16'h0000 : win_q + 16'h0001;
      if (warm_q != `CST_STARTUP_SAMPLES) begin
        warm_q <= warm_q + 8'h01;
      end else begin
        ent_ok_q <= 1'b1;
      end
    end
  end

  // failures seen this cycle; entry to error takes them all at once
  wire integ_bad = integ_digest != integ_stored;
  wire kat_bad = kat_result != kat_expected;
  wire kat_busy = (st_q == S_HW) || (st_q == S_FW);
  wire integ_fail_now = (st_q == S_INTEG) && issued_q && integ_done && integ_bad;
  wire kat_fail_now = kat_busy && issued_q && kat_done && kat_bad;
  wire pct_ok = pct_sign_ok && pct_verify_ok;
  wire pct_fail_now = (st_q == S_PCT) && pct_done && !pct_ok;
  wire any_fail = (ent_fail || integ_fail_now || kat_fail_now || pct_fail_now)
      && (st_q != S_ERR);
  // output opens only in operation, after warm-up, and never on a failing cycle
  wire out_open = (st_q == S_OPER) && ent_ok_q && !any_fail;

  // conditioned entropy output, gated off unless operational
  always @(posedge clk) begin
    if (!reset_n) begin
      ent_out_valid_q <= 1'b0;
      ent_out_data_q <= {SW{1'b0}};
    end else if (s_take) begin
      ent_out_valid_q <= out_open;
      ent_out_data_q <= s_data;
    end else if (ent_out_ready || st_q == S_ERR || any_fail) begin
      ent_out_valid_q <= 1'b0;
    end
  end

  // firmware tests follow the hardware ones in the select space
  wire [3:0] n_hw = N_HW[3:0];
  wire [3:0] n_fw = N_FW[3:0];

  // sequencing of power-up, conditional and error states
  always @(posedge clk) begin
    if (!reset_n) begin
      st_q <= S_FETCH;
      skip_fw_q <= 1'b0;
      idx_q <= 4'h0;
      issued_q <= 1'b0;
      hold_q <= 8'h00;
      pend_q <= 1'b0;
      rec_rd_q <= 1'b0;
      rec_wr_q <= 1'b0;
      integ_start_q <= 1'b0;
      kat_start_q <= 1'b0;
      kat_sel_q <= 4'h0;
      pct_start_q <= 1'b0;
      svc_done_q <= 1'b0;
      operational_q <= 1'b0;
      out_enable_q <= 1'b0;
      crypto_allow_q <= 1'b0;
      fail_q <= 1'b0;
      module_reset_q <= 1'b0;
    end else begin
      rec_wr_q <= 1'b0;
      integ_start_q <= 1'b0;
      kat_start_q <= 1'b0;
      pct_start_q <= 1'b0;
      svc_done_q <= 1'b0;
      // early requests are remembered and answered once on entry to operation
      if (svc_req && st_q != S_OPER) begin
        pend_q <= 1'b1;
      end
      case (st_q)
        S_FETCH: begin
          // record read stays high until the store answers
          rec_rd_q <= !rec_valid;
          if (rec_valid) begin
            skip_fw_q <= rec_passed;
            issued_q <= 1'b0;
            st_q <= S_INTEG;
          end
        end
        S_INTEG: begin
          if (!issued_q) begin
            integ_start_q <= 1'b1;
            issued_q <= 1'b1;
          end else if (integ_done) begin
            issued_q <= 1'b0;
            idx_q <= 4'h0;
            st_q <= integ_bad ? S_ERR : S_HW;
          end
        end
        S_HW, S_FW: begin
          // one test in flight; result and expected are sampled with done
          if (!issued_q) begin
            kat_start_q <= 1'b1;
            kat_sel_q <= (st_q == S_FW) ? idx_q + n_hw : idx_q;
            issued_q <= 1'b1;
          end else if (kat_done) begin
            issued_q <= 1'b0;
            if (kat_bad) begin
              st_q <= S_ERR;
            end else if (st_q == S_HW && idx_q == n_hw - 4'h1) begin
              idx_q <= 4'h0;
              st_q <= skip_fw_q ? S_WAIT : S_FW;
            end else if (st_q == S_FW && idx_q == n_fw - 4'h1) begin
              rec_wr_q <= 1'b1;
              st_q <= S_WAIT;
            end else begin
              idx_q <= idx_q + 4'h1;
            end
          end
        end
        S_WAIT: begin
          // hold off until entropy start-up samples pass
          if (ent_ok_q) begin
            st_q <= S_OPER;
            operational_q <= 1'b1;
            out_enable_q <= 1'b1;
            crypto_allow_q <= 1'b1;
          end
        end
        S_OPER: begin
          if (pend_q || svc_req) begin
            svc_done_q <= 1'b1;
            pend_q <= 1'b0;
          end
          if (keygen_done) begin
            pct_start_q <= 1'b1;
            crypto_allow_q <= 1'b0;
            st_q <= S_PCT;
          end
        end
        S_PCT: begin
          // crypto starts stay refused until the pairwise check answers
          if (pct_done) begin
            if (pct_sign_ok && pct_verify_ok) begin
              crypto_allow_q <= 1'b1;
              st_q <= S_OPER;
            end else begin
              st_q <= S_ERR;
            end
          end
        end
        S_ERR: begin
          operational_q <= 1'b0;
          out_enable_q <= 1'b0;
          crypto_allow_q <= 1'b0;
          fail_q <= 1'b1;
          if (hold_q != `CST_RESET_HOLD) begin
            hold_q <= hold_q + 8'h01;
            module_reset_q <= 1'b1;
          end else begin
            // reset pulse done: rerun from the record fetch
            module_reset_q <= 1'b0;
            fail_q <= 1'b0;
            hold_q <= 8'h00;
            skip_fw_q <= 1'b0;
            issued_q <= 1'b0;
            st_q <= S_FETCH;
          end
        end
        default: begin
          st_q <= S_ERR;
        end
      endcase

      // any failure enters error at once, raising the reset request with the fail flag
      // so that no start, completion or output slips out on the failing edge
      if (any_fail) begin
        st_q <= S_ERR;
        hold_q <= 8'h00;
        rec_rd_q <= 1'b0;
        rec_wr_q <= 1'b0;
        integ_start_q <= 1'b0;
        kat_start_q <= 1'b0;
        pct_start_q <= 1'b0;
        svc_done_q <= 1'b0;
        pend_q <= pend_q || svc_req;
        operational_q <= 1'b0;
        out_enable_q <= 1'b0;
        crypto_allow_q <= 1'b0;
        fail_q <= 1'b1;
        module_reset_q <= 1'b1;
      end
    end
  end
endmodule // cst_sequencer

// ==== verilog/cst_regs.vh ====
// constants for the crypto self-test sequencer
`ifndef CST_REGS_VH
`define CST_REGS_VH
`define CST_SAMPLE_W 256
`define CST_RCT_CUTOFF 8'h03
`define CST_APT_WINDOW 16'h0400
`define CST_APT_CUTOFF 16'h0060
`define CST_APT_LOW 16'h0020
`define CST_PAT_W 4
`define CST_STARTUP_SAMPLES 8'h04
`define CST_RESET_HOLD 8'h08
`endif

// ==== verilog/cst_fifo.v ====
// parameterised valid/ready fifo for entropy samples
`timescale 1ns/1ps
module cst_fifo #(
  parameter WIDTH = 256,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  // clock and reset
  input wire clk,
  input wire reset_n,
  // fill side
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  // drain side
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_q;
  reg [AW-1:0] rd_q;
  reg [AW:0] cnt_q;
  wire do_wr = in_valid && in_ready;
  wire do_rd = out_valid && out_ready;
  assign in_ready = (cnt_q != DEPTH[AW:0]);
  assign out_valid = (cnt_q != {(AW+1){1'b0}});
  assign out_data = mem[rd_q];
  always @(posedge clk) begin
    if (do_wr) begin
      mem[wr_q] <= in_data;
    end
  end
  always @(posedge clk) begin
    if (!reset_n) begin
      wr_q <= {AW{1'b0}};
      rd_q <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end else begin
      if (do_wr) begin
        wr_q <= (wr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_q + 1'b1;
      end
      if (do_rd) begin
        rd_q <= (rd_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + {{AW{1'b0}}, do_wr} - {{AW{1'b0}}, do_rd};
    end
  end
endmodule // cst_fifo

// ==== verif/cst_partner.sv ====
// far side: pass record store, check engines and entropy source
`timescale 1ns/1ps
module cst_partner (
  // design requests
  input wire clk,
  input wire rec_rd_q,
  input wire rec_wr_q,
  input wire integ_start_q,
  input wire kat_start_q,
  input wire [3:0] kat_sel_q,
  input wire pct_start_q,
  input wire ent_ready,
  // faults ordered by the bench
  input wire rec_force,
  input wire rec_val,
  input wire bad_integ,
  input wire [3:0] bad_sel,
  input wire [1:0] bad_pct,
  input wire rep_ent,
  // answers
  output wire rec_valid,
  output wire rec_passed,
  output wire integ_done,
  output wire [255:0] integ_digest,
  output wire [255:0] integ_stored,
  output wire kat_done,
  output wire [511:0] kat_result,
  output wire [511:0] kat_expected,
  output wire pct_done,
  output wire pct_sign_ok,
  output wire pct_verify_ok,
  output wire ent_valid,
  output wire [255:0] ent_data
);
  // record outlives module resets, as battery-backed storage does
  reg rec_q = 1'b0;
  reg [2:0] done_q = 3'h0;
  reg [255:0] x_q = {4{64'h9E3779B97F4A7C15}};
  wire [255:0] x1 = x_q ^ (x_q << 13);
  wire [255:0] x2 = x1 ^ (x1 >> 7);
  always @(posedge clk) begin
    rec_q <= rec_force ? rec_val : rec_q | rec_wr_q;
    done_q <= {pct_start_q, kat_start_q, integ_start_q};
    if (ent_ready && !rep_ent) begin
      x_q <= x2 ^ (x2 << 17);
    end
  end
  // idle answers are inverted so a stale value never matches
  assign rec_valid = rec_rd_q;
  assign rec_passed = rec_q ^ !rec_rd_q;
  assign {pct_done, kat_done, integ_done} = done_q;
  assign integ_stored = 256'h5A;
  assign integ_digest = integ_stored ^ {256{!integ_done | bad_integ}};
  assign kat_expected = {508'h0, kat_sel_q};
  assign kat_result = kat_expected ^ {512{!kat_done | bad_sel == kat_sel_q}};
  assign pct_sign_ok = pct_done & !bad_pct[0];
  assign pct_verify_ok = pct_done & !bad_pct[1];
  assign ent_valid = 1'b1;
  assign ent_data = x_q;
endmodule // cst_partner

// ==== verif/cst_seq_assertions.sv ====
// port assertions for the self-test sequencer
`timescale 1ns/1ps
module cst_seq_chk (
  // watched ports
  input wire clk,
  input wire reset_n,
  input wire rec_rd_q,
  input wire rec_valid,
  input wire integ_start_q,
  input wire integ_done,
  input wire [255:0] integ_digest,
  input wire [255:0] integ_stored,
  input wire kat_done,
  input wire [511:0] kat_result,
  input wire [511:0] kat_expected,
  input wire keygen_done,
  input wire pct_start_q,
  input wire pct_done,
  input wire pct_sign_ok,
  input wire pct_verify_ok,
  input wire ent_out_valid_q,
  input wire svc_done_q,
  input wire operational_q,
  input wire out_enable_q,
  input wire crypto_allow_q,
  input wire fail_q,
  input wire module_reset_q
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  a_err_blocks_io: assert property (
    fail_q |-> !(out_enable_q || crypto_allow_q || ent_out_valid_q || operational_q))
    else $error("io open in error");
  a_err_resets: assert property (fail_q |-> module_reset_q)
    else $error("fail without reset");
  a_rec_then_test: assert property (
    rec_rd_q && rec_valid |-> ##2 (integ_start_q || fail_q))
    else $error("no integrity start");
  a_integ_fails: assert property (
    integ_done && integ_digest != integ_stored |=> fail_q)
    else $error("digest mismatch missed");
  a_kat_fails: assert property (kat_done && kat_result != kat_expected |=> fail_q)
    else $error("answer mismatch missed");
  a_pct_fails: assert property (
    pct_done && !(pct_sign_ok && pct_verify_ok) |-> ##[1:3] fail_q)
    else $error("pairwise failure missed");
  a_pct_follows: assert property (keygen_done && operational_q |-> ##[1:4] pct_start_q)
    else $error("no pairwise check");
  a_svc_gated: assert property (svc_done_q |-> operational_q)
    else $error("early completion");
endmodule // cst_seq_chk
bind cst_sequencer cst_seq_chk cst_seq_chk_inst (.clk, .reset_n, .rec_rd_q, .rec_valid,
  .integ_start_q, .integ_done, .integ_digest, .integ_stored, .kat_done, .kat_result,
  .kat_expected, .keygen_done, .pct_start_q, .pct_done, .pct_sign_ok, .pct_verify_ok,
  .ent_out_valid_q, .svc_done_q, .operational_q, .out_enable_q, .crypto_allow_q, .fail_q,
  .module_reset_q);

// ==== verif/tb.sv ====
// self-checking bench for the self-test sequencer
`timescale 1ns/1ps
module tb;
  reg clk = 1'b0, reset_n = 1'b0, keygen_done = 1'b0, ent_out_ready = 1'b1, svc_req = 1'b0;
  reg rec_force = 1'b0, rec_val = 1'b0, bad_integ = 1'b0, rep_ent = 1'b0;
  reg [3:0] bad_sel = 4'hF;
  reg [1:0] bad_pct = 2'h0;
  wire rec_rd_q, rec_valid, rec_passed, rec_wr_q, integ_start_q, integ_done, kat_start_q;
  wire kat_done, pct_start_q, pct_done, pct_sign_ok, pct_verify_ok, ent_valid, ent_ready;
  wire ent_out_valid_q, svc_done_q, operational_q, out_enable_q, crypto_allow_q, fail_q;
  wire module_reset_q;
  wire [3:0] kat_sel_q;
  wire [255:0] integ_digest, integ_stored, ent_data, ent_out_data_q;
  wire [511:0] kat_result, kat_expected;
  int failures = 0, cmp_count = 0, cyc = 0, k, n;
  logic [31:0] d;
  // row: force record, record value, bad digest, expect fail, bad test, test starts
  logic [15:0] rows [6] = '{16'h8F0D, 16'h0F04, 16'hBF00, 16'h9203, 16'h9C0D, 16'hC604};
  cst_sequencer cst_sequencer_inst (.clk, .reset_n, .rec_rd_q, .rec_valid, .rec_passed,
    .rec_wr_q, .integ_start_q, .integ_done, .integ_digest, .integ_stored, .kat_start_q,
    .kat_sel_q, .kat_done, .kat_result, .kat_expected, .keygen_done, .pct_start_q, .pct_done,
    .pct_sign_ok, .pct_verify_ok, .ent_valid, .ent_ready, .ent_data, .ent_out_valid_q,
    .ent_out_data_q, .ent_out_ready, .svc_req, .svc_done_q, .operational_q, .out_enable_q,
    .crypto_allow_q, .fail_q, .module_reset_q);
  cst_partner cst_partner_inst (.clk, .rec_rd_q, .rec_wr_q, .integ_start_q, .kat_start_q,
    .kat_sel_q, .pct_start_q, .ent_ready, .rec_force, .rec_val, .bad_integ, .bad_sel, .bad_pct,
    .rep_ent, .rec_valid, .rec_passed, .integ_done, .integ_digest, .integ_stored, .kat_done,
    .kat_result, .kat_expected, .pct_done, .pct_sign_ok, .pct_verify_ok, .ent_valid, .ent_data);
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  task automatic give_verdict;
    $display("compares %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // counts test starts and completions until operational, or with want_op low until failure
  task automatic settle(input logic want_op);
    k = 0;
    n = 0;
    for (int i = 0; i < 600; i++) begin
      @(posedge clk);
      #1;
      k += kat_start_q;
      n += svc_done_q;
      if (want_op ? operational_q === 1'b1 : fail_q === 1'b1) break;
    end
  endtask
  task automatic rst;
    reset_n <= 1'b0;
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    rec_force <= 1'b0;
    #1;
    chk("quiet", {operational_q, out_enable_q, rec_rd_q}, 0);
  endtask
  initial begin
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      give_verdict;
    end
  end
  initial begin
    foreach (rows[i]) begin
      @(posedge clk);
      {rec_force, rec_val, bad_integ} <= rows[i][15:13];
      bad_sel <= rows[i][11:8];
      rst;
      settle(!rows[i][12]);
      chk("kat starts", k, rows[i][7:0]);
      chk("fail", fail_q, rows[i][12]);
      chk("io open", out_enable_q & crypto_allow_q, !rows[i][12]);
    end
    // keygen with good, bad-sign and bad-verify answers; service asked during recovery
    for (int m = 0; m < 3; m++) begin
      @(posedge clk);
      bad_pct <= m[1:0];
      keygen_done <= 1'b1;
      @(posedge clk);
      keygen_done <= 1'b0;
      repeat (6) @(posedge clk);
      #1;
      chk("pct fail", fail_q, m != 0);
      @(posedge clk);
      bad_pct <= 2'h0;
      svc_req <= m == 2;
      @(posedge clk);
      svc_req <= 1'b0;
      settle(1'b1);
      chk("recovered", operational_q, 1);
      @(posedge clk);
      #1;
      n += svc_done_q;
      chk("svc done", n, m == 2);
    end
    @(posedge clk);
    rep_ent <= 1'b1;
    settle(1'b0);
    chk("repeat fail", fail_q, 1);
    @(posedge clk);
    rep_ent <= 1'b0;
    settle(1'b1);
    chk("monitor rerun", operational_q, 1);
    // stall the consumer until the buffer refuses, then drain
    @(posedge clk);
    ent_out_ready <= 1'b0;
    settle(1'b1);
    n = 0;
    repeat (40) @(posedge clk);
    #1;
    chk("fifo full", ent_ready, 0);
    d = ent_out_data_q[31:0];
    @(posedge clk);
    ent_out_ready <= 1'b1;
    #1;
    chk("data held", ent_out_data_q[31:0], d);
    settle(1'b0);
    chk("fifo drains", k == 0 && ent_out_valid_q | ent_ready, 1);
    chk("no fail", fail_q, 0);
    chk("data moves", ent_out_data_q[31:0] != d, 1);
    give_verdict;
  end
endmodule // tb
